// File: ccfe_top.sv
// current channel front end: route, gain trim, phase b synthesis, dc blocker, fifo
`default_nettype none

module ccfe_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 4,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // occupancy
  output logic      [LVL_W-1:0] level
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != LVL_W'(DEPTH));
  assign out_valid = (level != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      level <= '0;
    end else if (push && !pop) begin
      level <= level + LVL_W'(1);
    end else if (pop && !push) begin
      level <= level - LVL_W'(1);
    end
  end
endmodule : ccfe_fifo

module ccfe_top #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic                             mclk,
  input  wire logic                             reset,
  // wishbone slave
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [ccfe_pkg::ADDR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [ccfe_pkg::WORD_W-1:0]      wb_dat_i,
  output logic      [ccfe_pkg::WORD_W-1:0]      wb_dat_o,
  output logic                                  wb_ack_o,
  // converter samples, one set per strobe
  input  wire logic                             conv_valid,
  output logic                                  conv_ready,
  input  wire logic signed [ccfe_pkg::SAMPLE_W-1:0] conv_sample0,
  input  wire logic signed [ccfe_pkg::SAMPLE_W-1:0] conv_sample1,
  input  wire logic signed [ccfe_pkg::SAMPLE_W-1:0] conv_sample2,
  input  wire logic signed [ccfe_pkg::SAMPLE_W-1:0] conv_sample3,
  // filtered samples toward rms and power datapaths
  output logic                                  out_valid,
  input  wire logic                             out_ready,
  output logic signed [ccfe_pkg::SAMPLE_W-1:0]  phase_a_current,
  output logic signed [ccfe_pkg::SAMPLE_W-1:0]  phase_b_current,
  output logic signed [ccfe_pkg::SAMPLE_W-1:0]  phase_c_current,
  output logic signed [ccfe_pkg::SAMPLE_W-1:0]  neutral_current,
  // shared filter bypass for the voltage datapaths
  output logic                                  highpass_off
);
  import ccfe_pkg::*;

  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);

  // clip a wide signed value into one sample
  function automatic logic signed [SAMPLE_W-1:0] ccfe_sat(input logic signed [63:0] v);
    logic signed [63:0] hi;
    logic signed [63:0] lo;
    hi = 64'(signed'({1'b0, {(SAMPLE_W-1){1'b1}}}));
    lo = -hi - 64'sd1;
    if (v > hi) begin
      ccfe_sat = hi[SAMPLE_W-1:0];
    end else if (v < lo) begin
      ccfe_sat = lo[SAMPLE_W-1:0];
    end else begin
      ccfe_sat = v[SAMPLE_W-1:0];
    end
  endfunction : ccfe_sat

  // byte-lane merge of a bus write
  function automatic logic [WORD_W-1:0] ccfe_merge(input logic [WORD_W-1:0] old_v,
                                                  input logic [WORD_W-1:0] new_v,
                                                  input logic [3:0]        sel);
    ccfe_merge = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        ccfe_merge[8*b +: 8] = new_v[8*b +: 8];
      end
    end
  endfunction : ccfe_merge

  // software registers
  logic [NCH*ROUTE_W-1:0]     converter_route_mux;
  logic                       derive_b_from_a_c;
  logic [CORNER_W-1:0]        highpass_corner_sel;
  logic signed [GAIN_W-1:0]   current_gain_word [NCH];

  // datapath
  logic signed [SAMPLE_W-1:0] conv [NCH];
  logic signed [SAMPLE_W-1:0] routed [NCH];
  logic signed [SAMPLE_W-1:0] gained [NCH];
  logic signed [SAMPLE_W-1:0] s1_data [NCH];
  logic signed [SAMPLE_W-1:0] hp_in [NCH];
  logic signed [SAMPLE_W-1:0] hp_out [NCH];
  logic signed [SAMPLE_W-1:0] derived_b;
  logic                       s1_valid;
  logic                       push;
  logic                       fifo_in_ready;
  logic [NCH*SAMPLE_W-1:0]    fifo_in_data;
  logic [NCH*SAMPLE_W-1:0]    fifo_out_data;
  logic [LVL_W-1:0]           fifo_level;
  logic [5:0]                 hpf_shift;

  // bus
  logic                       bus_req;
  logic                       bus_wr;
  logic [WORD_W-1:0]          next_rdata;

  assign conv[0] = conv_sample0;
  assign conv[1] = conv_sample1;
  assign conv[2] = conv_sample2;
  assign conv[3] = conv_sample3;

  // wishbone slave
  // answer one cycle after the strobe; writes land at the ack edge
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (wb_adr_i == OFF_ROUTE) begin
      next_rdata[NCH*ROUTE_W-1:0] = converter_route_mux;
    end else if (wb_adr_i == OFF_ACCUM) begin
      next_rdata[DERIVE_B_BIT] = derive_b_from_a_c;
    end else if (wb_adr_i == OFF_SETUP0) begin
      next_rdata[HPF_OFF_BIT] = highpass_off;
    end else if (wb_adr_i == OFF_SETUP2) begin
      next_rdata[CORNER_LSB +: CORNER_W] = highpass_corner_sel;
    end else if (wb_adr_i == OFF_STATUS) begin
      next_rdata[STAT_LEVEL_LSB +: LVL_W] = fifo_level;
      next_rdata[STAT_STAGE_BIT]          = s1_valid;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wb_adr_i == OFF_GAIN_BASE + ADDR_W'(i) * GAIN_STRIDE) begin
          next_rdata = current_gain_word[i];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_dat_o <= '0;
    end else if (bus_req) begin
      wb_dat_o <= next_rdata;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      converter_route_mux <= RST_ROUTE;
    end else if (bus_wr && wb_adr_i == OFF_ROUTE && wb_sel_i[0]) begin
      converter_route_mux <= wb_dat_i[NCH*ROUTE_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      derive_b_from_a_c <= 1'b0;
    end else if (bus_wr && wb_adr_i == OFF_ACCUM && wb_sel_i[0]) begin
      derive_b_from_a_c <= wb_dat_i[DERIVE_B_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      highpass_off <= 1'b0;
    end else if (bus_wr && wb_adr_i == OFF_SETUP0 && wb_sel_i[0]) begin
      highpass_off <= wb_dat_i[HPF_OFF_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      highpass_corner_sel <= RST_CORNER;
    end else if (bus_wr && wb_adr_i == OFF_SETUP2 && wb_sel_i[0]) begin
      highpass_corner_sel <= wb_dat_i[CORNER_LSB +: CORNER_W];
    end
  end

  // stream control
  // a held sample stalls the converters until the fifo takes it
  assign push       = s1_valid & fifo_in_ready;
  assign conv_ready = ~s1_valid | fifo_in_ready;

  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_valid <= 1'b0;
    end else if (conv_ready) begin
      s1_valid <= conv_valid;
    end
  end

  // phase b rebuilt from the trimmed a and c samples
  assign derived_b = ccfe_sat(-64'(s1_data[0]) - 64'(s1_data[2]));
  // larger code means longer time constant, so a lower corner
  assign hpf_shift = HPF_SHIFT_BASE + 6'(highpass_corner_sel);

  // per-channel datapath
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic signed [GAIN_W+SAMPLE_W-1:0] prod;
    logic signed [63:0]                gsum;
    logic signed [HPF_ACC_W-1:0]       dc_acc;
    logic signed [HPF_ACC_W:0]         dc_err;
    logic signed [SAMPLE_W-1:0]        dc_est;

    assign routed[i] = conv[converter_route_mux[ROUTE_W*i +: ROUTE_W]];

    always_ff @(posedge mclk) begin
      if (reset) begin
        current_gain_word[i] <= RST_GAIN;
      end else if (bus_wr && wb_adr_i == OFF_GAIN_BASE + ADDR_W'(i) * GAIN_STRIDE) begin
        current_gain_word[i] <= ccfe_merge(current_gain_word[i], wb_dat_i, wb_sel_i);
      end
    end

    // x * (1 + g / 2^27)
    assign prod      = routed[i] * current_gain_word[i];
    assign gsum      = 64'(routed[i]) + 64'(prod >>> GAIN_FRAC);
    assign gained[i] = ccfe_sat(gsum);

    always_ff @(posedge mclk) begin
      if (reset) begin
        s1_data[i] <= '0;
      end else if (conv_ready) begin
        s1_data[i] <= gained[i];
      end
    end

    if (i == 1) begin : g_b
      assign hp_in[i] = derive_b_from_a_c ? derived_b : s1_data[i];
    end else begin : g_other
      assign hp_in[i] = s1_data[i];
    end

    // one-pole dc tracker; output is sample minus tracked offset
    assign dc_est = dc_acc[HPF_ACC_W-1:HPF_FRAC];
    assign dc_err = (HPF_ACC_W+1)'(hp_in[i]) * (HPF_ACC_W+1)'(2 ** HPF_FRAC)
                    - (HPF_ACC_W+1)'(dc_acc);

    always_ff @(posedge mclk) begin
      if (reset) begin
        dc_acc <= '0;
      end else if (push) begin
        dc_acc <= dc_acc + HPF_ACC_W'(dc_err >>> hpf_shift);
      end
    end

    assign hp_out[i] = highpass_off ? hp_in[i]
                     : ccfe_sat(64'(hp_in[i]) - 64'(dc_est));
    assign fifo_in_data[SAMPLE_W*i +: SAMPLE_W] = hp_out[i];
  end

  // output buffer
  ccfe_fifo #(
    .WIDTH (NCH*SAMPLE_W),
    .DEPTH (FIFO_DEPTH),
    .LVL_W (LVL_W)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (s1_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  assign phase_a_current = fifo_out_data[0*SAMPLE_W +: SAMPLE_W];
  assign phase_b_current = fifo_out_data[1*SAMPLE_W +: SAMPLE_W];
  assign phase_c_current = fifo_out_data[2*SAMPLE_W +: SAMPLE_W];
  assign neutral_current = fifo_out_data[3*SAMPLE_W +: SAMPLE_W];

endmodule : ccfe_top
`default_nettype wire

// File: ccfe_pkg.sv
// constants and register map of the current channel front end
`default_nettype none
package ccfe_pkg;

  // datapath geometry
  localparam int SAMPLE_W  = 24;
  localparam int GAIN_W    = 32;
  localparam int GAIN_FRAC = 27;
  localparam int NCH       = 4;
  localparam int ROUTE_W   = 2;
  localparam int WORD_W    = 32;
  localparam int ADDR_W    = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ROUTE     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ACCUM     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SETUP0    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SETUP2    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_GAIN_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] GAIN_STRIDE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h20;

  // field positions
  localparam int DERIVE_B_BIT    = 0;
  localparam int HPF_OFF_BIT     = 0;
  localparam int CORNER_LSB      = 0;
  localparam int CORNER_W        = 3;
  localparam int STAT_LEVEL_LSB  = 0;
  localparam int STAT_STAGE_BIT  = 8;

  // values after reset
  localparam logic [NCH*ROUTE_W-1:0] RST_ROUTE  = 8'he4;
  localparam logic [CORNER_W-1:0]    RST_CORNER = 3'h0;
  localparam logic [GAIN_W-1:0]      RST_GAIN   = 32'h0000_0000;

  // filter: step shift = base + corner code; code 0 is the 1.25 Hz corner
  localparam logic [5:0] HPF_SHIFT_BASE = 6'h0a;
  localparam int         HPF_FRAC       = 24;
  localparam int         HPF_ACC_W      = SAMPLE_W + HPF_FRAC;

endpackage : ccfe_pkg
`default_nettype wire

// File: ccfe_top_unused_guard.sv
// spare source slot of the current channel front end, holds no logic
`default_nettype none
`default_nettype wire

// File: ccfe_top_asserts.sv
// port-level assertions of the current channel front end
`default_nettype none
module ccfe_top_asserts (
  // clock and reset
  input wire logic                                mclk,
  input wire logic                                reset,
  // wishbone
  input wire logic                                wb_cyc_i,
  input wire logic                                wb_stb_i,
  input wire logic                                wb_we_i,
  input wire logic [ccfe_pkg::ADDR_W-1:0]         wb_adr_i,
  input wire logic [ccfe_pkg::WORD_W-1:0]         wb_dat_o,
  input wire logic                                wb_ack_o,
  // streams
  input wire logic                                conv_valid,
  input wire logic                                conv_ready,
  input wire logic                                out_valid,
  input wire logic                                out_ready,
  input wire logic signed [ccfe_pkg::SAMPLE_W-1:0] phase_a_current,
  input wire logic                                highpass_off
);
  timeunit 1ns;
  timeprecision 1ns;
  import ccfe_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40 |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
  refuse_full_a: assert property (!conv_ready |-> out_valid)
    else $error("refused with nothing buffered");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(phase_a_current))
    else $error("result dropped while stalled");
  reset_state_a: assert property ($fell(reset) |-> !out_valid && !highpass_off && conv_ready)
    else $error("bad state after reset");
  bypass_write_a: assert property ($changed(highpass_off) |-> $past(wb_ack_o && wb_we_i))
    else $error("bypass changed without write");
  fill_latency_a: assert property ($rose(out_valid) |-> $past(conv_valid && conv_ready, 2))
    else $error("result latency wrong");
endmodule : ccfe_top_asserts
bind ccfe_top ccfe_top_asserts u_asserts (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .conv_valid(conv_valid), .conv_ready(conv_ready), .out_valid(out_valid),
  .out_ready(out_ready), .phase_a_current(phase_a_current), .highpass_off(highpass_off));
`default_nettype wire

// File: ccfe_tb_sink.sv
// downstream datapath model taking result sets, promptly or with stalls
`default_nettype none
module ccfe_tb_sink (
  // clock and reset
  input  wire logic                                mclk,
  input  wire logic                                reset,
  // pace set by the bench
  input  wire logic                                hold,
  input  wire logic                                slow,
  // result stream
  input  wire logic                                out_valid,
  output logic                                     out_ready,
  input  wire logic signed [ccfe_pkg::SAMPLE_W-1:0] a,
  input  wire logic signed [ccfe_pkg::SAMPLE_W-1:0] b,
  input  wire logic signed [ccfe_pkg::SAMPLE_W-1:0] c,
  input  wire logic signed [ccfe_pkg::SAMPLE_W-1:0] n,
  output int                                       count
);
  timeunit 1ns;
  timeprecision 1ns;
  import ccfe_pkg::*;
  logic                       tog;
  logic signed [SAMPLE_W-1:0] got [16][4];
  // slow mode accepts every other cycle only
  assign out_ready = !hold && (!slow || tog);
  always_ff @(posedge mclk) begin
    if (reset) begin
      tog <= 1'b0;
      count <= 0;
    end else begin
      tog <= !tog;
      if (out_valid && out_ready) begin
        got[count % 16] <= '{a, b, c, n};
        count <= count + 1;
      end
    end
  end
endmodule : ccfe_tb_sink
`default_nettype wire

// File: ccfe_tb.sv
// self-checking bench of the current channel front end
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ccfe_pkg::*;
  logic                       mclk, reset, cyc, stb, we, cv, hold, slow, ack, crdy, ov, hpo;
  logic [ADDR_W-1:0]          adr;
  logic [3:0]                 sel, wsel;
  logic [WORD_W-1:0]          dat, rdo, q;
  logic signed [SAMPLE_W-1:0] s0, s1, s2, s3, ra, rb, rc, rn;
  logic                       ordy;
  int                         cnt, k, j, bad_count, total_checks;
  ccfe_top u_dut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .conv_valid(cv), .conv_ready(crdy), .conv_sample0(s0), .conv_sample1(s1),
    .conv_sample2(s2), .conv_sample3(s3), .out_valid(ov), .out_ready(ordy),
    .phase_a_current(ra), .phase_b_current(rb), .phase_c_current(rc),
    .neutral_current(rn), .highpass_off(hpo));
  ccfe_tb_sink u_sink (.mclk(mclk), .reset(reset), .hold(hold), .slow(slow), .out_valid(ov),
    .out_ready(ordy), .a(ra), .b(rb), .c(rc), .n(rn), .count(cnt));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic lim(input int i);
    if (i >= 200) begin
      bad_count++;
      conclude();
    end
  endtask : lim
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, wsel};
    for (i = 0; i < 200 && ack !== 1'b1; i++) @(posedge mclk);
    lim(i);
    q = rdo;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic push(input int v [4]);
    int i;
    i = 0;
    @(posedge mclk);
    {cv, s0, s1, s2, s3} <= {1'b1, 24'(v[0]), 24'(v[1]), 24'(v[2]), 24'(v[3])};
    do begin
      @(posedge mclk);
      i++;
    end while (crdy !== 1'b1 && i < 200);
    lim(i);
    cv <= 1'b0;
  endtask : push
  task automatic res(input int e [4]);
    int i;
    for (i = 0; i < 200 && cnt <= k; i++) @(posedge mclk);
    lim(i);
    for (int m = 0; m < 4; m++) chk($sformatf("ch%0d", m), u_sink.got[k % 16][m], e[m]);
    k++;
  endtask : res
  initial begin
    {cyc, stb, we, cv, hold, slow, adr, sel, dat, s0, s1, s2, s3} = '0;
    {k, bad_count, total_checks} = '0;
    wsel = 4'hf;
    reset = 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    chk("hpo", hpo, 0);
    push('{4096, 4096, 4096, 4096});
    res('{4096, 4096, 4096, 4096});
    for (j = 0; j < 9; j++) begin
      wb(0, 8'(j * 4), 0);
      chk("reg", q, j == 0 ? 32'he4 : 32'h0);
    end
    wb(1, 8'h40, 32'hffff_ffff);
    wb(0, 8'h40, 0);
    chk("unmapped", q, 0);
    // step shift now one wider, so the tracker moves half as fast
    wb(1, OFF_SETUP2, 32'h1);
    push('{4096, 4096, 4096, 4096});
    res('{4092, 4092, 4092, 4092});
    push('{4096, 4096, 4096, 4096});
    res('{4091, 4091, 4091, 4091});
    wb(1, OFF_SETUP0, 32'h1);
    // the bit lands at the ack edge; look one edge later
    @(posedge mclk);
    chk("hpo", hpo, 1);
    push('{100, 200, 300, 400});
    res('{100, 200, 300, 400});
    wb(1, OFF_ROUTE, 32'h1b);
    push('{100, 200, 300, 400});
    res('{400, 300, 200, 100});
    wb(1, OFF_ROUTE, 32'he4);
    wb(1, 8'h10, 32'h0400_0000);
    // only byte lane 0 may change; the added low byte keeps the 1.5 trim
    wsel = 4'h1;
    wb(1, 8'h10, 32'hffff_ffff);
    wsel = 4'hf;
    wb(0, 8'h10, 0);
    chk("gain_a", q, 32'h0400_00ff);
    wb(1, 8'h14, 32'h0200_0000);
    wb(1, 8'h18, 32'hfe00_0000);
    wb(1, 8'h1c, 32'hfc00_0000);
    push('{100, 200, 300, 400});
    res('{150, 250, 225, 200});
    wb(1, OFF_ACCUM, 32'h1);
    @(posedge mclk);
    hold <= 1'b1;
    for (j = 0; j < 5; j++) push('{100, 200, 300, 400});
    @(posedge mclk);
    chk("ready", crdy, 0);
    wb(0, OFF_STATUS, 0);
    chk("status", q, 32'h104);
    {hold, slow} <= 2'b01;
    for (j = 0; j < 5; j++) res('{150, -375, 225, 200});
    conclude();
  end
endmodule : tb
`default_nettype wire
